/* rtl/ccr_core.sv */
// CPU core control register with priority flag and program window enable.
//
// Chosen here: strobed register access and the register addresses.

module ccr_core (
  input  wire logic                       i_clk,
  input  wire logic                       i_srst,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  input  wire logic [ccr_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [ccr_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_prio_load,
  input  wire logic [3:0]                 i_prio_level,
  input  wire logic                       i_user_irq_req,
  output logic      [ccr_pkg::DATA_W-1:0] o_rdata,
  output logic                            o_priority_above_seven_flag,
  output logic                            o_program_window_enable,
  output logic                            o_user_irq_take,
  output logic      [3:0]                 o_prio_level
);

  // ---------------------------------------------------------------------
  // Request bundle
  // ---------------------------------------------------------------------
  ccr_pkg::ccr_bus_req_t req;

  assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  // ---------------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------------
  logic       flag;
  logic       win_en;
  logic [2:0] prio_low;
  logic       next_flag;
  logic       next_win_en;
  logic [2:0] next_prio_low;
  logic       ctrl_wr;

  assign ctrl_wr = req.wr && (req.addr == ccr_pkg::CORE_CONTROL_OFF);

  // The four-bit level is the flag above three low bits, so the flag is one
  // exactly when the level exceeds seven. A hardware load wins over a
  // software clear in the same cycle.
  always_comb begin
    next_flag     = flag;
    next_win_en   = win_en;
    next_prio_low = prio_low;
    if (ctrl_wr) begin
      next_win_en = req.wdata[ccr_pkg::WINDOW_EN_BIT];
      if (!req.wdata[ccr_pkg::PRIO_FLAG_BIT]) begin
        next_flag = 1'b0;
      end
    end
    if (i_prio_load) begin
      next_flag     = (i_prio_level > ccr_pkg::PRIO_THRESHOLD);
      next_prio_low = i_prio_level[2:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      flag     <= ccr_pkg::PRIO_FLAG_RST;
      win_en   <= ccr_pkg::WINDOW_EN_RST;
      prio_low <= ccr_pkg::PRIO_RST;
    end else begin
      flag     <= next_flag;
      win_en   <= next_win_en;
      prio_low <= next_prio_low;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs to the core
  // ---------------------------------------------------------------------
  assign o_priority_above_seven_flag = flag;
  assign o_program_window_enable     = win_en;
  assign o_user_irq_take             = i_user_irq_req && !flag;
  assign o_prio_level                = {flag, prio_low};

  // ---------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------
  ccr_pkg::ccr_rd_sel_t       rd_sel;
  logic [ccr_pkg::DATA_W-1:0] ctrl_word;
  logic [ccr_pkg::DATA_W-1:0] prio_word;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[ccr_pkg::PRIO_FLAG_BIT] = flag;
    ctrl_word[ccr_pkg::WINDOW_EN_BIT] = win_en;
    prio_word = {12'h000, flag, prio_low};
    if (!req.rd) begin
      rd_sel = ccr_pkg::CCR_RD_IDLE;
    end else if (req.addr == ccr_pkg::CORE_CONTROL_OFF) begin
      rd_sel = ccr_pkg::CCR_RD_CTRL;
    end else if (req.addr == ccr_pkg::PRIORITY_OFF) begin
      rd_sel = ccr_pkg::CCR_RD_PRIO;
    end else begin
      rd_sel = ccr_pkg::CCR_RD_NONE;
    end
  end

  ccr_read_mux u_rd (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_sel       (rd_sel),
    .i_ctrl_word (ctrl_word),
    .i_prio_word (prio_word),
    .o_rdata     (o_rdata)
  );

endmodule

/* rtl/ccr_pkg.sv */
// Package with constants and types for the CPU core control register.
package ccr_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam int          ADDR_W           = 4;
  localparam int          DATA_W           = 16;
  localparam logic [3:0]  CORE_CONTROL_OFF = 4'h0;
  localparam logic [3:0]  PRIORITY_OFF     = 4'h1;

  // ---------------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------------
  localparam int          PRIO_FLAG_BIT    = 3;
  localparam int          WINDOW_EN_BIT    = 2;
  localparam logic        PRIO_FLAG_RST    = 1'b0;
  localparam logic        WINDOW_EN_RST    = 1'b0;
  localparam logic [2:0]  PRIO_RST         = 3'h0;
  localparam logic [3:0]  PRIO_THRESHOLD   = 4'h7;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ccr_bus_req_t;

  typedef enum logic [1:0] {
    CCR_RD_IDLE,
    CCR_RD_CTRL,
    CCR_RD_PRIO,
    CCR_RD_NONE
  } ccr_rd_sel_t;

endpackage

/* rtl/ccr_read_mux.sv */
// Registered read data selection for the core control register bank.
module ccr_read_mux (
  input  wire logic                       i_clk,
  input  wire logic                       i_srst,
  input  wire ccr_pkg::ccr_rd_sel_t       i_sel,
  input  wire logic [ccr_pkg::DATA_W-1:0] i_ctrl_word,
  input  wire logic [ccr_pkg::DATA_W-1:0] i_prio_word,
  output logic      [ccr_pkg::DATA_W-1:0] o_rdata
);

  logic [ccr_pkg::DATA_W-1:0] next_rdata;

  always_comb begin
    case (i_sel)
      ccr_pkg::CCR_RD_CTRL: next_rdata = i_ctrl_word;
      ccr_pkg::CCR_RD_PRIO: next_rdata = i_prio_word;
      default:              next_rdata = '0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule

/* testbench/ccr_core_chk.sv */
// Port checker for the CPU core control register.
module ccr_core_chk (
  input logic        i_clk,
  input logic        i_srst,
  input logic        i_wr,
  input logic        i_rd,
  input logic [3:0]  i_addr,
  input logic [15:0] i_wdata,
  input logic        i_prio_load,
  input logic [3:0]  i_prio_level,
  input logic        i_user_irq_req,
  input logic [15:0] o_rdata,
  input logic        o_priority_above_seven_flag,
  input logic        o_program_window_enable,
  input logic        o_user_irq_take,
  input logic [3:0]  o_prio_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_ctrl_read: assert property ($past(i_rd) && $past(i_addr) == 4'h0 |->
    o_rdata == {12'h0, $past(o_priority_above_seven_flag),
    $past(o_program_window_enable), 2'h0}) else $error("control readback");
  a_flag_level: assert property (i_prio_load |=>
    o_priority_above_seven_flag == ($past(i_prio_level) > 4'h7))
    else $error("flag vs level");
  a_irq_mask: assert property (o_user_irq_take ==
    (i_user_irq_req && !o_priority_above_seven_flag)) else $error("irq mask");
  a_load_level: assert property (i_prio_load |=>
    o_prio_level == $past(i_prio_level)) else $error("level load");
  a_no_sw_set: assert property (!o_priority_above_seven_flag &&
    !i_prio_load |=> !o_priority_above_seven_flag) else $error("flag set");
  a_win_write: assert property (i_wr && i_addr == 4'h0 |=>
    o_program_window_enable == $past(i_wdata[2])) else $error("window write");
  a_win_hold: assert property (!(i_wr && i_addr == 4'h0) |=>
    $stable(o_program_window_enable)) else $error("window moved");
  a_prio_read: assert property ($past(i_rd) && $past(i_addr) == 4'h1 |->
    o_rdata == {12'h0, $past(o_prio_level)}) else $error("level readback");
  a_rdata_idle: assert property (!$past(i_rd) || $past(i_addr) > 4'h1 |->
    o_rdata == 16'h0000) else $error("idle read data");
endmodule

bind ccr_core ccr_core_chk ccr_core_chk_i (.*);

/* testbench/test_cpu_control_register.sv */
// Self-checking bench for the CPU core control register.
`define CHK(g, e) chk(24'(g), 24'(e));
module test_cpu_control_register;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = '0, i_srst = '1, i_wr = '0, i_rd = '0;
  logic        i_prio_load = '0, i_user_irq_req = '1;
  logic [3:0]  i_addr = '0, i_prio_level = '0, o_lvl;
  logic [15:0] i_wdata = '0, o_rdata;
  logic        o_flag, o_win, o_take;
  int          error_cnt = 0, n_checks = 0;
  logic [4:0]  rows [4] = '{5'h00, 5'h0e, 5'h11, 5'h1f};
  ccr_core ccr_core_i (
    .i_clk, .i_srst, .i_wr, .i_rd, .i_addr, .i_wdata, .i_prio_load,
    .i_prio_level, .i_user_irq_req, .o_rdata,
    .o_priority_above_seven_flag(o_flag), .o_program_window_enable(o_win),
    .o_user_irq_take(o_take), .o_prio_level(o_lvl));
  initial forever #2 i_clk = ~i_clk;
  task automatic chk(input logic [23:0] g, e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic op(input logic w, r, l, input logic [3:0] a,
                    input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= w;
    i_rd <= r;
    i_prio_load <= l;
    i_addr <= a;
    i_wdata <= d;
    i_prio_level <= d[3:0];
    @(posedge i_clk);
    i_wr <= '0;
    i_rd <= '0;
    i_prio_load <= '0;
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #5000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_srst <= '0;
    #1 `CHK({o_flag, o_win, o_lvl, o_rdata}, 0)
    foreach (rows[k]) begin
      op(1'h0, 1'h0, 1'h1, 4'h0, 16'(rows[k][4:1]));
      `CHK({o_lvl, o_flag, o_take}, {rows[k], !rows[k][0]})
      op(1'h0, 1'h1, 1'h0, 4'h0, 16'h0);
      `CHK(o_rdata, {rows[k][0], 3'h0})
    end
    op(1'h1, 1'h0, 1'h0, 4'h0, 16'hffff);
    op(1'h0, 1'h1, 1'h0, 4'h0, 16'h0);
    `CHK({o_flag, o_win, o_rdata}, 18'h3000c)
    op(1'h1, 1'h0, 1'h0, 4'h0, 16'h0);
    `CHK({o_flag, o_win, o_lvl}, 6'h07)
    op(1'h1, 1'h0, 1'h0, 4'h5, 16'h4);
    op(1'h0, 1'h1, 1'h0, 4'h5, 16'h0);
    `CHK({o_win, o_rdata}, 0)
    op(1'h1, 1'h0, 1'h0, 4'h0, 16'h000c);
    `CHK({o_flag, o_win, o_take}, 3'h3)
    @(posedge i_clk);
    i_user_irq_req <= '0;
    #1 `CHK(o_take, 0)
    // Load above seven and a software clear in one cycle: the load wins.
    @(posedge i_clk);
    i_wr <= '1;
    i_prio_load <= '1;
    i_addr <= 4'h0;
    i_wdata <= 16'h0004;
    i_prio_level <= 4'h9;
    op(1'h0, 1'h1, 1'h0, 4'h1, 16'h0);
    `CHK({o_flag, o_win, o_lvl, o_rdata}, 22'h390009)
    op(1'h1, 1'h0, 1'h0, 4'h1, 16'hffff);
    op(1'h0, 1'h1, 1'h0, 4'h1, 16'h0);
    `CHK({o_win, o_rdata}, 17'h10009)
    @(posedge i_clk);
    i_srst <= '1;
    repeat (3) @(posedge i_clk);
    i_srst <= '0;
    #1 `CHK({o_flag, o_win, o_lvl}, 0)
    conclude();
  end
endmodule
